// ---- core/frs_pkg.sv ----
// Purpose: Shared constants and types for the rate control and result status bank
// Assumes: 10-bit host I/O address, 8-bit data
// Notes: Bit positions refer to the config register and the result status bytes
package frs_pkg;
  // ==========================================
  // Host addresses
  localparam logic [9:0] CFG_ADDR = 10'h03F7;
  localparam logic [9:0] STAT_ADDR = 10'h03F7;
  // ==========================================
  // Rate selection
  localparam logic [1:0] RATE_250 = 2'h2;
  localparam logic [1:0] RATE_300 = 2'h1;
  localparam int RATE_LO = 0;
  localparam int RATE_HI = 1;
  localparam int PRECOMP_BIT = 2;
  // ==========================================
  // Status byte 0 fields
  localparam int B0_CC_HI = 7;
  localparam int B0_CC_LO = 6;
  localparam int B0_SEEK = 5;
  localparam int B0_EQUIP = 4;
  localparam int B0_HEAD = 2;
  // ==========================================
  // Status byte 1 fields
  localparam int B1_EOT = 7;
  localparam int B1_CRC = 5;
  localparam int B1_OVR = 4;
  localparam int B1_NODATA = 2;
  localparam int B1_WP = 1;
  localparam int B1_MARK = 0;
  // ==========================================
  // Counts
  localparam logic [6:0] RECAL_STEPS = 7'h50;
  localparam logic [1:0] INDEX_LIMIT = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ==========================================
  // Register modes
  typedef enum {FRS_MODE_AT, FRS_MODE_PS, FRS_MODE_LEGACY} frs_mode_t;
  // Command outcome events from the sequencer, all same-clock pulses
  typedef struct packed {
    logic cmd_start;
    logic cmd_done;
    logic [1:0] code;
    logic seek_done;
    logic step;
    logic rel_under;
    logic sector_over;
    logic crc_bad;
    logic overrun;
    logic no_data;
    logic data_mark_missing;
  } frs_ev_t;
endpackage : frs_pkg

// ---- core/frs_rate_status.sv ----
// Purpose: Config rate control register and result status bytes 0 and 1
// Assumes: Sequencer supplies same-clock event pulses; drive pins are asynchronous
// Notes: Soft reset leaves rate, precomp flag and density untouched
//
// Contract
// R1: Write-only config register at 3F7; bits 1:0 choose data rate.
// R2: Hardware reset sets rate 250 Kbps; software reset leaves it.
// R3: Host writes zeros to reserved upper config bits.
// R4: Legacy mode stores bit 2 as precomp flag with no effect.
// R5: Legacy mode reads precomp flag on bit 2; survives software reset.
// R6: Density output high after hardware reset; software resets leave it.
// R7: Result phase presents status bytes of the last command.
// R8: Byte 0 bits 7:6 carry the completion code.
// R9: Byte 0 bit 5 set when seek, relative seek or recalibrate ends.
// R10: Equipment fault when track zero absent after 80 recalibrate steps.
// R11: Equipment fault when relative seek steps outward past track zero.
// R12: Byte 0 bit 2 head, bits 1:0 selected drive.
// R13: Unused status bits read zero.
// R14: Byte 1 bit 7 set when access passes last sector.
// R15: Byte 1 bit 5 set on ID or data CRC mismatch.
// R16: Byte 1 bit 4 set on overrun or underrun.
// R17: Byte 1 bit 2 set when sector, ID or track sequence not found.
// R18: Byte 1 bit 1 set when write protect rises during writes; the code sets it whenever write protect is high during a write.
// R19: Byte 1 bit 0 set on missing ID mark or data mark.
// R20: Mode bits pick first, second or legacy register mode.
// R21: Flags clear at each command start.
`timescale 1ns/1ps
module frs_rate_status
  import frs_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rstn,
  input wire logic soft_reset,
  // Host I/O
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Mode straps
  input wire logic mode_ident,
  input wire logic mode_sub_bit,
  // Sequencer
  input wire frs_ev_t ev,
  input wire logic recal_active,
  input wire logic id_search,
  input wire logic write_cmd,
  input wire logic head_now,
  input wire logic [1:0] drive_now,
  // Drive pins
  input wire logic track_zero_in,
  input wire logic index_pulse_in,
  input wire logic write_protect_in,
  // Outputs
  output logic [1:0] rate_choice,
  output logic precomp_off_flag,
  output logic density_select_out,
  output logic [7:0] result_status_byte0,
  output logic [7:0] result_status_byte1
);

  // ==========================================
  // Mode decode
  frs_mode_t mode;
  always_comb begin
    if (mode_ident) begin
      mode = FRS_MODE_AT;
    end else if (mode_sub_bit) begin
      mode = FRS_MODE_PS;
    end else begin
      mode = FRS_MODE_LEGACY; // see R20
    end
  end
  logic legacy;
  assign legacy = (mode == FRS_MODE_LEGACY);

  logic cfg_wr;
  assign cfg_wr = io_wr && (io_addr == CFG_ADDR);

  // ==========================================
  // Config rate control
  // Only a hardware reset touches these; soft_reset is not wired here on purpose
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rate_choice <= RATE_250; // see R2
    end else if (cfg_wr) begin
      rate_choice <= io_wdata[RATE_HI:RATE_LO]; // see R1
    end
  end

  // Upper bits are ignored; the host keeps them zero, see R3
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      precomp_off_flag <= 1'b0;
    end else if (cfg_wr && legacy) begin
      precomp_off_flag <= io_wdata[PRECOMP_BIT]; // see R4
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      density_select_out <= 1'b1; // see R6
    end else begin
      density_select_out <= (rate_choice == RATE_250) || (rate_choice == RATE_300);
    end
  end

  // ==========================================
  // Rate status read port
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= BYTE_ZERO;
    end else if (io_rd && io_addr == STAT_ADDR && legacy) begin
      io_rdata <= {5'h00, precomp_off_flag, rate_choice}; // see R5
    end else begin
      io_rdata <= BYTE_ZERO;
    end
  end

  // ==========================================
  // Pin synchronisers: level moves once stages two and three agree
  logic [2:0] tz_s;
  logic [2:0] ix_s;
  logic [2:0] wp_s;
  logic tz_lvl;
  logic ix_lvl;
  logic wp_lvl;
  logic ix_prev;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tz_s <= 3'h0;
      ix_s <= 3'h0;
      wp_s <= 3'h0;
    end else begin
      tz_s <= {tz_s[1:0], track_zero_in};
      ix_s <= {ix_s[1:0], index_pulse_in};
      wp_s <= {wp_s[1:0], write_protect_in};
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tz_lvl <= 1'b0;
      ix_lvl <= 1'b0;
      wp_lvl <= 1'b0;
      ix_prev <= 1'b0;
    end else begin
      if (tz_s[1] == tz_s[2]) begin
        tz_lvl <= tz_s[2];
      end
      if (ix_s[1] == ix_s[2]) begin
        ix_lvl <= ix_s[2];
      end
      if (wp_s[1] == wp_s[2]) begin
        wp_lvl <= wp_s[2];
      end
      ix_prev <= ix_lvl;
    end
  end
  logic ix_rise;
  assign ix_rise = ix_lvl && !ix_prev;

  // ==========================================
  // Recalibrate step and index counters
  logic [6:0] step_cnt;
  logic [1:0] ix_cnt;
  logic clr;
  assign clr = ev.cmd_start || soft_reset;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      step_cnt <= 7'h00;
    end else if (clr || !recal_active) begin
      step_cnt <= 7'h00;
    end else if (ev.step && step_cnt != RECAL_STEPS) begin
      step_cnt <= step_cnt + 7'h01;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ix_cnt <= 2'h0;
    end else if (clr || !id_search) begin
      ix_cnt <= 2'h0;
    end else if (ix_rise && ix_cnt != INDEX_LIMIT) begin
      ix_cnt <= ix_cnt + 2'h1;
    end
  end

  // ==========================================
  // Event terms
  logic eq_set;
  logic mark_set;
  logic wp_set;
  assign eq_set = (recal_active && step_cnt == RECAL_STEPS && !tz_lvl) // see R10
                  || ev.rel_under; // see R11
  assign mark_set = (id_search && ix_cnt == INDEX_LIMIT) // see R19
                    || ev.data_mark_missing; // see R19
  assign wp_set = write_cmd && wp_lvl; // see R18

  // ==========================================
  // Status byte 0
  // A set in the clearing cycle wins so no event is lost
  logic [1:0] completion_code;
  logic seek_finished;
  logic equipment_fault;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      completion_code <= 2'h0;
    end else if (ev.cmd_done) begin
      completion_code <= ev.code; // see R8
    end else if (clr) begin
      completion_code <= 2'h0; // see R21
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seek_finished <= 1'b0;
      equipment_fault <= 1'b0;
    end else begin
      seek_finished <= (seek_finished && !clr) || ev.seek_done; // see R9
      equipment_fault <= (equipment_fault && !clr) || eq_set; // see R21
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_status_byte0 <= BYTE_ZERO;
    end else begin
      result_status_byte0 <= {completion_code, seek_finished, equipment_fault, // see R7
                              1'b0, head_now, drive_now}; // see R12 see R13
    end
  end

  // ==========================================
  // Status byte 1
  logic sector_over;
  logic crc_fault;
  logic overrun;
  logic sector_not_found;
  logic write_protect_hit;
  logic mark_missing;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sector_over <= 1'b0;
      crc_fault <= 1'b0;
      overrun <= 1'b0;
      sector_not_found <= 1'b0;
      write_protect_hit <= 1'b0;
      mark_missing <= 1'b0;
    end else begin
      sector_over <= (sector_over && !clr) || ev.sector_over; // see R14
      crc_fault <= (crc_fault && !clr) || ev.crc_bad; // see R15
      overrun <= (overrun && !clr) || ev.overrun; // see R16
      sector_not_found <= (sector_not_found && !clr) || ev.no_data; // see R17
      write_protect_hit <= (write_protect_hit && !clr) || wp_set; // see R18
      mark_missing <= (mark_missing && !clr) || mark_set; // see R19
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_status_byte1 <= BYTE_ZERO;
    end else begin
      result_status_byte1 <= {sector_over, 1'b0, crc_fault, overrun, 1'b0, // see R13
                              sector_not_found, write_protect_hit, mark_missing};
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  rate_write_a: assert property (cfg_wr |=> rate_choice == $past(io_wdata[1:0])) // see R1
    else $error("rate not taken from write");
  rate_keep_a: assert property (soft_reset && !cfg_wr |=> $stable(rate_choice)) // see R2
    else $error("soft reset moved rate");
  precomp_mode_a: assert property (cfg_wr && !legacy |=> $stable(precomp_off_flag)) // see R4
    else $error("precomp changed outside legacy mode");
  precomp_read_a: assert property (io_rd && io_addr == STAT_ADDR && legacy
      |=> io_rdata[2] == $past(precomp_off_flag)) // see R5
    else $error("precomp read wrong");
  density_keep_a: assert property (soft_reset && $stable(rate_choice)
      |=> $stable(density_select_out)) // see R6
    else $error("density moved on soft reset");
  code_latch_a: assert property (ev.cmd_done
      |=> ##1 result_status_byte0[7:6] == $past(ev.code, 2)) // see R8
    else $error("completion code wrong");
  seek_end_a: assert property (ev.seek_done |=> ##1 result_status_byte0[B0_SEEK]) // see R9
    else $error("seek end missing");
  recal_fault_a: assert property (recal_active && ev.step && step_cnt == 7'h4f
      && !tz_lvl && !clr ##1 recal_active && !clr && !tz_lvl
      |=> equipment_fault) // see R10
    else $error("recal fault missing");
  unused_zero_a: assert property (!result_status_byte0[3] && !result_status_byte1[6]
      && !result_status_byte1[3]) // see R13
    else $error("unused status bit set");
  wp_flag_a: assert property (write_cmd && wp_lvl |=> ##1 result_status_byte1[B1_WP]) // see R18
    else $error("write protect flag missing");
  clear_start_a: assert property (ev.cmd_start && !ev.crc_bad |=> !crc_fault) // see R21
    else $error("flag not cleared at start");
  set_wins_a: assert property (ev.cmd_start && ev.overrun |=> overrun) // see R16
    else $error("overrun lost on clear");
  rel_fault_a: assert property (ev.rel_under |=> ##1 result_status_byte0[B0_EQUIP]) // see R11
    else $error("relative seek fault missing");
  head_echo_a: assert property (rstn // see R12
      |=> result_status_byte0[2:0] == $past({head_now, drive_now}))
    else $error("head or drive echo wrong");

endmodule : frs_rate_status

// ---- verif/frs_host_model.sv ----
// Purpose: Host side of the rate bank's I/O port, one byte per strobe
// Assumes: Strobes are taken on the rising clock edge
// Notes: Called by hierarchical task calls from the bench
`timescale 1ns/1ps
module frs_host_model
  import frs_pkg::*;
(
  // Bus
  input wire logic clock,
  input wire logic [7:0] io_rdata,
  output logic [9:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // ==========================================
  // Idle bus
  initial begin
    io_addr = 10'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // ==========================================
  // Accesses; callers keep reserved upper bits at zero
  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    #1;
    io_addr = CFG_ADDR;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clock);
    #1;
    io_wr = 1'b0;
    // A released bus must not keep showing the last byte
    io_wdata = ~d;
  endtask : wr
  task automatic rd(output logic [7:0] d);
    @(posedge clock);
    #1;
    io_addr = STAT_ADDR;
    io_rd = 1'b1;
    @(posedge clock);
    #1;
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd
endmodule : frs_host_model

// ---- verif/fdc_rate_ctrl_and_result_status_bench.sv ----
// Purpose: Self-checking bench for the rate register and result status bytes
// Assumes: Event pulses one cycle wide, pins held long enough to pass the filters
// Notes: Head and drive rest at 3'b110, so byte 0 low bits echo that outside the code loop
`timescale 1ns/1ps
module fdc_rate_ctrl_and_result_status_bench
  import frs_pkg::*;
;
  logic clock, rstn, soft_reset, mode_ident, mode_sub_bit, io_wr, io_rd;
  logic recal_active, id_search, write_cmd, track_zero_in, index_pulse_in, write_protect_in;
  logic precomp_off_flag, density_select_out, head_now;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata, byte0, byte1, d;
  logic [1:0] rate_choice, drive_now;
  frs_ev_t ev;
  int fails = 0;
  int n_checks = 0;
  int b1 [5] = '{B1_MARK, B1_NODATA, B1_OVR, B1_CRC, B1_EOT};
  frs_host_model i_frs_host (.clock(clock), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  frs_rate_status i_frs_rate_status (.clock(clock), .rstn(rstn), .soft_reset(soft_reset),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .mode_ident(mode_ident), .mode_sub_bit(mode_sub_bit), .ev(ev),
    .recal_active(recal_active), .id_search(id_search), .write_cmd(write_cmd),
    .head_now(head_now), .drive_now(drive_now), .track_zero_in(track_zero_in),
    .index_pulse_in(index_pulse_in), .write_protect_in(write_protect_in),
    .rate_choice(rate_choice), .precomp_off_flag(precomp_off_flag),
    .density_select_out(density_select_out), .result_status_byte0(byte0),
    .result_status_byte1(byte1));
  // ==========================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Status byte lands one edge after the pulse is taken
  task automatic pulse(input frs_ev_t e);
    @(posedge clock);
    #1;
    ev = e;
    @(posedge clock);
    #1;
    ev = '0;
    repeat (2) @(posedge clock);
    #1;
  endtask : pulse
  task automatic rate_is(input logic [7:0] exp);
    check({5'h00, precomp_off_flag, rate_choice}, exp);
  endtask : rate_is
  // ==========================================
  // Clock, watchdog, stimulus
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #400_000;
    fails++;
    give_verdict();
  end
  initial begin
    {rstn, soft_reset, mode_ident, mode_sub_bit, recal_active, id_search} = 6'h00;
    {write_cmd, track_zero_in, index_pulse_in, write_protect_in} = 4'h0;
    {head_now, drive_now} = 3'h6;
    ev = '0;
    repeat (8) @(posedge clock);
    #1;
    rstn = 1'b1;
    rate_is({6'h00, RATE_250});
    check({7'h00, density_select_out}, 8'h01);
    check(byte0, 8'h00);
    i_frs_host.wr(8'h07);
    rate_is(8'h07);
    @(posedge clock);
    #1;
    i_frs_host.rd(d);
    check(d, 8'h07);
    soft_reset = 1'b1;
    @(posedge clock);
    #1;
    soft_reset = 1'b0;
    @(posedge clock);
    #1;
    rate_is(8'h07);
    check({7'h00, density_select_out}, 8'h00);
    mode_ident = 1'b1;
    i_frs_host.wr(8'h01);
    rate_is(8'h05);
    i_frs_host.rd(d);
    check(d, 8'h00);
    {mode_ident, mode_sub_bit} = 2'b01;
    i_frs_host.wr(8'h00);
    rate_is(8'h04);
    mode_sub_bit = 1'b0;
    i_frs_host.wr(8'h02);
    i_frs_host.rd(d);
    check(d, 8'h02);
    for (int k = 0; k < 5; k++) begin
      pulse(12'h800);
      pulse(12'h001 << k);
      check(byte1, 8'h01 << b1[k]);
    end
    for (int c = 0; c < 4; c++) begin
      {head_now, drive_now} = {c[0], c[1:0]};
      pulse(12'h800);
      pulse({2'b01, c[1:0], 8'h00});
      check(byte0, {c[1:0], 3'h0, c[0], c[1:0]});
    end
    {head_now, drive_now} = 3'h6;
    pulse(12'h080);
    check(byte0, 8'hE6);
    pulse(12'h020);
    check(byte0, 8'hF6);
    pulse(12'h800);
    check(byte0, 8'h06);
    recal_active = 1'b1;
    repeat (79) pulse(12'h040);
    check(byte0, 8'h06);
    // Track zero present at the 80th step must hold the fault off
    track_zero_in = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    pulse(12'h040);
    check(byte0, 8'h06);
    track_zero_in = 1'b0;
    for (int i = 0; i < 8 && byte0[B0_EQUIP] !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check(byte0, 8'h16);
    recal_active = 1'b0;
    pulse(12'h800);
    write_cmd = 1'b1;
    write_protect_in = 1'b1;
    for (int i = 0; i < 12 && byte1[B1_WP] !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check(byte1, 8'h02);
    write_cmd = 1'b0;
    pulse(12'h800);
    check(byte1, 8'h00);
    id_search = 1'b1;
    for (int p = 0; p < 2; p++) begin
      check(byte1, 8'h00);
      index_pulse_in = 1'b1;
      repeat (6) @(posedge clock);
      #1;
      index_pulse_in = 1'b0;
      repeat (6) @(posedge clock);
      #1;
    end
    for (int i = 0; i < 8 && byte1[B1_MARK] !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check(byte1, 8'h01);
    // Move rate, flag and density off their reset values so the reset is seen
    i_frs_host.wr(8'h07);
    repeat (2) @(posedge clock);
    #1;
    rate_is(8'h07);
    check({7'h00, density_select_out}, 8'h00);
    rstn = 1'b0;
    #1;
    rate_is({6'h00, RATE_250});
    check({7'h00, density_select_out}, 8'h01);
    give_verdict();
  end
endmodule : fdc_rate_ctrl_and_result_status_bench
